// ==== logic/scc_sector_ctrl.sv ====
`default_nettype none
module scc_victim import scc_pkg::*; #(
   parameter int WAYS = 4,
   parameter int CW   = 3,
   parameter int IW   = $clog2(WAYS)
) (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire logic                req,
   input  wire logic                part_en,
   input  wire logic [1:0]          req_sector,
   input  wire logic [WAYS-1:0]     way_valid,
   input  wire logic [2*WAYS-1:0]   way_sector,
   input  wire logic [4*CW-1:0]     cap,
   input  wire logic [IW-1:0]       lru_way,
   output logic                     victim_valid,
   output logic [IW-1:0]            victim_way,
   output logic [1:0]               store_sector
);
   localparam int NW = $clog2(WAYS + 1);
   logic [NW-1:0]   occ [SCC_SECTORS];
   logic [WAYS-1:0] full_way;
   logic [WAYS-1:0] full_q;
   logic [IW-1:0]   next_victim;
   // occupancy is counted per sector from the way tags, so no counters drift
   always_comb begin
      for (int s = 0; s < SCC_SECTORS; s++) occ[s] = '0;
      for (int w = 0; w < WAYS; w++) begin
         occ[way_sector[2*w +: 2]] = occ[way_sector[2*w +: 2]] + NW'(way_valid[w]);
      end
   end
   generate
      for (genvar w = 0; w < WAYS; w++) begin : g_full
         assign full_way[w] = way_valid[w] &&
            (8'(occ[way_sector[2*w +: 2]]) >= 8'(cap[CW*way_sector[2*w +: 2] +: CW]));
      end
   endgenerate
   // invalid way first, then a sector at or over capacity, then plain replacement
   always_comb begin
      next_victim = lru_way;
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (part_en && full_way[w]) next_victim = IW'(w);
      end
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (!way_valid[w]) next_victim = IW'(w);
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         victim_valid <= 1'b0;
         victim_way   <= '0;
         store_sector <= 2'h0;
         full_q       <= '0;
      end else begin
         victim_valid <= req;
         if (req) begin
            victim_way   <= next_victim;
            store_sector <= req_sector;
            full_q       <= full_way;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_victim_over_cap: assert property (
      req && part_en && (|full_way) && (&way_valid) |=> full_q[victim_way])
      else $error("victim taken from a sector below its maximum");
   a_fill_tag_kept: assert property (
      req |=> victim_valid && store_sector == $past(req_sector))
      else $error("fill did not carry the access sector");
endmodule
module scc_sector_ctrl import scc_pkg::*; #(
   parameter int L1_WAYS = 4,
   parameter int L2_WAYS = 16
) (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       sr_valid,
   input  wire logic                       sr_write,
   input  wire logic [1:0]                 sr_el,
   input  wire logic                       sr_secure,
   input  wire logic [1:0]                 sr_op0,
   input  wire logic [2:0]                 sr_op1,
   input  wire logic [3:0]                 sr_crn,
   input  wire logic [3:0]                 sr_crm,
   input  wire logic [2:0]                 sr_op2,
   input  wire logic [63:0]                sr_wdata,
   output logic                            sr_done,
   output logic [63:0]                     sr_rdata,
   output logic                            sr_trap,
   output logic [1:0]                      sr_trap_el,
   output logic [5:0]                      sr_trap_class,
   output logic                            sr_undef,
   input  wire logic                       peer_set_wr,
   input  wire logic                       peer_set_sel,
   input  wire logic [63:0]                peer_set_data,
   output logic                            set_wr,
   output logic                            set_wr_sel,
   output logic [63:0]                     set_wr_data,
   input  wire logic                       acc_valid,
   input  wire logic                       acc_fetch,
   input  wire logic                       acc_cacheable,
   input  wire logic                       acc_tag_enable,
   input  wire logic [63:0]                acc_addr,
   output logic                            l1_sector_valid,
   output logic [1:0]                      l1_sector,
   output logic                            l2_sector_valid,
   output logic [1:0]                      l2_sector,
   input  wire logic                       hit_valid,
   input  wire logic [1:0]                 hit_line_sector,
   input  wire logic [1:0]                 hit_acc_sector,
   output logic                            line_sector_wr,
   output logic [1:0]                      line_sector_new,
   input  wire logic                       l1_partition_en,
   input  wire logic                       l1_fill_req,
   input  wire logic [1:0]                 l1_fill_sector,
   input  wire logic [L1_WAYS-1:0]         l1_way_valid,
   input  wire logic [2*L1_WAYS-1:0]       l1_way_sector,
   input  wire logic [$clog2(L1_WAYS)-1:0] l1_lru_way,
   output logic                            l1_victim_valid,
   output logic [$clog2(L1_WAYS)-1:0]      l1_victim_way,
   output logic [1:0]                      l1_store_sector,
   input  wire logic                       l2_partition_en,
   input  wire logic                       l2_fill_req,
   input  wire logic [1:0]                 l2_fill_sector,
   input  wire logic [L2_WAYS-1:0]         l2_way_valid,
   input  wire logic [2*L2_WAYS-1:0]       l2_way_sector,
   input  wire logic [$clog2(L2_WAYS)-1:0] l2_lru_way,
   output logic                            l2_victim_valid,
   output logic [$clog2(L2_WAYS)-1:0]      l2_victim_way,
   output logic [1:0]                      l2_store_sector
);
   logic        level1_access_enable;
   logic        level0_access_enable;
   logic [63:0] sector_allocation_control;
   logic [63:0] l2_sector_capacity_set0;
   logic [63:0] l2_sector_capacity_set1;
   logic [63:0] l1_sector_capacity;
   // register decode
   wire [13:0] key      = {sr_op1, sr_crn, sr_crm, sr_op2};
   wire        op0_ok   = sr_op0 == SCC_OP0;
   wire        sel_ctrl = op0_ok && key == SCC_KEY_CTRL;
   wire        sel_alc  = op0_ok && key == SCC_KEY_ALLOC;
   wire        sel_set0 = op0_ok && key == SCC_KEY_SET0;
   wire        sel_set1 = op0_ok && key == SCC_KEY_SET1;
   wire        sel_l1c  = op0_ok && key == SCC_KEY_L1CAP;
   wire        sel_win  = op0_ok && key == SCC_KEY_WIN;
   wire        mapped   = sel_ctrl | sel_alc | sel_set0 | sel_set1 | sel_l1c | sel_win;
   wire        pair     = sector_allocation_control[SCC_PAIR_BIT];
   wire        mode     = sector_allocation_control[SCC_MODE_BIT];
   wire [1:0]  fallback = sector_allocation_control[SCC_FALLBK_LSB +: 2];
   // privilege checks
   wire is_el0   = sr_el == SCC_EL0;
   wire ns_el1   = sr_el == SCC_EL1 && !sr_secure;
   wire priv     = !is_el0 && !ns_el1;
   wire el0_reg  = sel_l1c | sel_win;
   wire undef    = !mapped || (is_el0 && !el0_reg);
   wire trap_el1 = !undef && is_el0 &&
                   !(level1_access_enable && level0_access_enable);
   wire trap_el2 = !undef && ns_el1 && !level1_access_enable &&
                   !(sel_ctrl && !sr_write);
   wire allowed  = !undef && !trap_el1 && !trap_el2;
   wire wr_ok    = sr_valid && sr_write && allowed;
   // window aliases the set chosen by pair-select
   wire [63:0] win_view = pair ? l2_sector_capacity_set1 : l2_sector_capacity_set0;
   wire        wr_set0  = wr_ok && (sel_set0 || (sel_win && !pair));
   wire        wr_set1  = wr_ok && (sel_set1 || (sel_win && pair));
   wire [63:0] set_data = sr_wdata & SCC_L2CAP_MASK;
   wire [63:0] ctrl_view = {level1_access_enable, level0_access_enable, 62'h0};
   wire [63:0] rd_mux =
      sel_ctrl ? ctrl_view : sel_alc ? sector_allocation_control :
      sel_set0 ? l2_sector_capacity_set0 : sel_set1 ? l2_sector_capacity_set1 :
      sel_l1c ? l1_sector_capacity : sel_win ? win_view : 64'h0;
   // sector selection
   wire [1:0] tag_sector_field = acc_addr[SCC_TAG_LSB +: 2];
   wire [1:0] data_sector = acc_tag_enable ? tag_sector_field : fallback;
   wire [1:0] next_l2_sector = {pair, acc_fetch ? fallback[0] : data_sector[0]};
   wire       cacheable_acc = acc_valid && acc_cacheable;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level1_access_enable      <= 1'b0;
         level0_access_enable      <= 1'b0;
         sector_allocation_control <= SCC_REG_RESET;
         l1_sector_capacity        <= SCC_REG_RESET;
      end else if (wr_ok) begin
         if (sel_ctrl && priv) level1_access_enable <= sr_wdata[SCC_L1AE_BIT];
         if (sel_ctrl) level0_access_enable <= sr_wdata[SCC_L0AE_BIT];
         if (sel_alc) sector_allocation_control <= sr_wdata & SCC_ALLOC_MASK;
         if (sel_l1c) l1_sector_capacity <= sr_wdata & SCC_L1CAP_MASK;
      end
   end
   // shared sets: a local write beats a peer write landing in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         l2_sector_capacity_set0 <= SCC_REG_RESET;
         l2_sector_capacity_set1 <= SCC_REG_RESET;
      end else begin
         if (wr_set0) l2_sector_capacity_set0 <= set_data;
         else if (peer_set_wr && !peer_set_sel)
            l2_sector_capacity_set0 <= peer_set_data & SCC_L2CAP_MASK;
         if (wr_set1) l2_sector_capacity_set1 <= set_data;
         else if (peer_set_wr && peer_set_sel)
            l2_sector_capacity_set1 <= peer_set_data & SCC_L2CAP_MASK;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sr_done       <= 1'b0;
         sr_rdata      <= 64'h0;
         sr_trap       <= 1'b0;
         sr_trap_el    <= 2'h0;
         sr_trap_class <= 6'h0;
         sr_undef      <= 1'b0;
         set_wr        <= 1'b0;
         set_wr_sel    <= 1'b0;
         set_wr_data   <= 64'h0;
      end else begin
         sr_done       <= sr_valid;
         sr_rdata      <= (sr_valid && !sr_write && allowed) ? rd_mux : 64'h0;
         sr_trap       <= sr_valid && (trap_el1 || trap_el2);
         sr_trap_el    <= trap_el1 ? SCC_EL1 : SCC_EL2;
         sr_trap_class <= (sr_valid && (trap_el1 || trap_el2)) ? SCC_TRAP_CLASS : 6'h0;
         sr_undef      <= sr_valid && undef;
         set_wr        <= wr_set0 || wr_set1;
         set_wr_sel    <= wr_set1;
         set_wr_data   <= set_data;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         l1_sector_valid <= 1'b0;
         l1_sector       <= 2'h0;
         l2_sector_valid <= 1'b0;
         l2_sector       <= 2'h0;
         line_sector_wr  <= 1'b0;
         line_sector_new <= 2'h0;
      end else begin
         l1_sector_valid <= cacheable_acc && !acc_fetch;
         l1_sector       <= data_sector;
         l2_sector_valid <= cacheable_acc;
         l2_sector       <= next_l2_sector;
         // a hit is never blocked here; only the stored tag may change
         line_sector_wr  <= hit_valid && !mode && hit_line_sector != hit_acc_sector;
         line_sector_new <= hit_acc_sector;
      end
   end
   // four sectors per level; second level draws them from two pairs
   wire [4*SCC_L1F_W-1:0] l1_caps;
   generate
      for (genvar s = 0; s < SCC_SECTORS; s++) begin : g_l1cap
         assign l1_caps[SCC_L1F_W*s +: SCC_L1F_W] =
            l1_sector_capacity[SCC_L1F_STEP*s +: SCC_L1F_W];
      end
   endgenerate
   wire [4*SCC_L2F_W-1:0] l2_caps = {
      l2_sector_capacity_set1[SCC_L2F1_LSB +: SCC_L2F_W],
      l2_sector_capacity_set1[SCC_L2F0_LSB +: SCC_L2F_W],
      l2_sector_capacity_set0[SCC_L2F1_LSB +: SCC_L2F_W],
      l2_sector_capacity_set0[SCC_L2F0_LSB +: SCC_L2F_W]};
   scc_victim #(.WAYS(L1_WAYS), .CW(SCC_L1F_W)) u_l1_victim (
      .clk          (clk),
      .resetn       (resetn),
      .req          (l1_fill_req),
      .part_en      (l1_partition_en),
      .req_sector   (l1_fill_sector),
      .way_valid    (l1_way_valid),
      .way_sector   (l1_way_sector),
      .cap          (l1_caps),
      .lru_way      (l1_lru_way),
      .victim_valid (l1_victim_valid),
      .victim_way   (l1_victim_way),
      .store_sector (l1_store_sector)
   );
   scc_victim #(.WAYS(L2_WAYS), .CW(SCC_L2F_W)) u_l2_victim (
      .clk          (clk),
      .resetn       (resetn),
      .req          (l2_fill_req),
      .part_en      (l2_partition_en),
      .req_sector   (l2_fill_sector),
      .way_valid    (l2_way_valid),
      .way_sector   (l2_way_sector),
      .cap          (l2_caps),
      .lru_way      (l2_lru_way),
      .victim_valid (l2_victim_valid),
      .victim_way   (l2_victim_way),
      .store_sector (l2_store_sector)
   );
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_ns_el1_req;
      sr_valid && ns_el1;
   endsequence
   a_trap_class_code: assert property (sr_done && sr_trap |-> sr_trap_class == 6'h18)
      else $error("trap class is not 0x18");
   a_ns_el1_trapped: assert property (
      s_ns_el1_req and (!level1_access_enable && sel_alc)
      |=> sr_trap && sr_trap_el == 2'h2)
      else $error("non-secure level 1 access not trapped to level 2");
   a_ctrl_read_ok: assert property (
      s_ns_el1_req and (sel_ctrl && !sr_write) |=> !sr_trap && sr_done)
      else $error("control read from level 1 trapped");
   a_el1_open: assert property (
      s_ns_el1_req and (level1_access_enable && mapped) |=> !sr_trap && !sr_undef)
      else $error("enabled level 1 access refused");
   a_el0_gate: assert property (
      sr_valid && is_el0 && el0_reg && !(level1_access_enable && level0_access_enable)
      |=> sr_trap && sr_trap_el == 2'h1)
      else $error("level 0 access not trapped to level 1");
   a_enable_guarded: assert property (
      s_ns_el1_req and (sr_write && sel_ctrl) |=> $stable(level1_access_enable))
      else $error("level 1 enable changed by non-secure level 1");
   a_window_route: assert property (
      wr_ok && sel_win && !pair |=> l2_sector_capacity_set0 == $past(set_data) && set_wr)
      else $error("window write missed set 0");
   a_resv_zero: assert property (
      sector_allocation_control[63:4] == 60'h0 && l1_sector_capacity[63:15] == 49'h0)
      else $error("reserved bits not zero");
   a_tag_sector: assert property (
      cacheable_acc && !acc_fetch && acc_tag_enable
      |=> l1_sector == $past(tag_sector_field) && l2_sector[0] == $past(tag_sector_field[0]))
      else $error("tag sector not used");
   a_fetch_refill: assert property (
      cacheable_acc && acc_fetch
      |=> !l1_sector_valid && l2_sector == {$past(pair), $past(fallback[0])})
      else $error("fetch sector wrong");
   a_hit_keep: assert property (hit_valid && mode |=> !line_sector_wr)
      else $error("line sector rewritten with keep policy");
   a_uncached_bare: assert property (
      acc_valid && !acc_cacheable |=> !l1_sector_valid && !l2_sector_valid)
      else $error("sector given to uncached access");
endmodule
`default_nettype wire

// ==== logic/scc_pkg.sv ====
`default_nettype none
package scc_pkg;
   localparam logic [1:0]  SCC_OP0        = 2'h3;
   localparam logic [13:0] SCC_KEY_CTRL   = 14'h05c0;
   localparam logic [13:0] SCC_KEY_ALLOC  = 14'h05c1;
   localparam logic [13:0] SCC_KEY_SET0   = 14'h07c2;
   localparam logic [13:0] SCC_KEY_SET1   = 14'h07c3;
   localparam logic [13:0] SCC_KEY_L1CAP  = 14'h1dc2;
   localparam logic [13:0] SCC_KEY_WIN    = 14'h1fc2;
   localparam int          SCC_L1AE_BIT   = 63;
   localparam int          SCC_L0AE_BIT   = 62;
   localparam int          SCC_MODE_BIT   = 3;
   localparam int          SCC_PAIR_BIT   = 2;
   localparam int          SCC_FALLBK_LSB = 0;
   localparam int          SCC_L1F_W      = 3;
   localparam int          SCC_L1F_STEP   = 4;
   localparam int          SCC_L2F_W      = 5;
   localparam int          SCC_L2F0_LSB   = 0;
   localparam int          SCC_L2F1_LSB   = 8;
   localparam int          SCC_TAG_LSB    = 56;
   localparam int          SCC_SECTORS    = 4;
   localparam logic [63:0] SCC_ALLOC_MASK = 64'h000000000000000f;
   localparam logic [63:0] SCC_L1CAP_MASK = 64'h0000000000007777;
   localparam logic [63:0] SCC_L2CAP_MASK = 64'h0000000000001f1f;
   localparam logic [63:0] SCC_REG_RESET  = 64'h0000000000000000;
   localparam logic [5:0]  SCC_TRAP_CLASS = 6'h18;
   typedef enum logic [1:0] {
      SCC_EL0 = 2'h0,
      SCC_EL1 = 2'h1,
      SCC_EL2 = 2'h2,
      SCC_EL3 = 2'h3
   } scc_el_t;
endpackage
`default_nettype wire

// ==== test/scc_core_model.sv ====
`default_nettype none
module scc_core_model (
   input  wire logic        clk,
   input  wire logic        sr_done,
   output logic             sr_valid,
   output logic             sr_write,
   output logic [1:0]       sr_el,
   output logic             sr_secure,
   output logic [1:0]       sr_op0,
   output logic [13:0]      sr_key,
   output logic [63:0]      sr_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {sr_valid, sr_write, sr_el, sr_secure, sr_op0, sr_key, sr_wdata} = '0;
   // released lines flip so a stale value never looks valid
   task automatic access(input logic w, input logic [1:0] el, input logic sec,
                         input logic [13:0] key, input logic [63:0] d, output logic ok);
      @(negedge clk);
      {sr_valid, sr_write, sr_el, sr_secure} = {1'b1, w, el, sec};
      {sr_op0, sr_key, sr_wdata} = {2'h3, key, d};
      @(negedge clk);
      ok = sr_done;
      sr_valid = 1'b0;
      sr_key = ~sr_key;
      sr_wdata = ~sr_wdata;
   endtask
endmodule
`default_nettype wire

// ==== test/sector_cache_control_tb_top.sv ====
`default_nettype none
module sector_cache_control_tb_top import scc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, resetn, sr_valid, sr_write, sr_secure, sr_done, sr_trap, sr_undef;
   logic [1:0]  sr_el, sr_op0, sr_trap_el;
   logic [13:0] sr_key;
   logic [63:0] sr_wdata, sr_rdata, peer_set_data, set_wr_data, acc_addr;
   logic [5:0]  sr_trap_class;
   logic        peer_set_wr, peer_set_sel, set_wr, set_wr_sel, acc_valid, acc_fetch;
   logic        acc_cacheable, acc_tag_enable, l1_sector_valid, l2_sector_valid, hit_valid;
   logic        line_sector_wr, l1_partition_en, l1_fill_req, l1_victim_valid;
   logic        l2_partition_en, l2_fill_req, l2_victim_valid;
   logic [1:0]  l1_sector, l2_sector, hit_line_sector, hit_acc_sector, line_sector_new;
   logic [1:0]  l1_fill_sector, l1_store_sector, l2_fill_sector, l2_store_sector;
   logic [3:0]  l1_way_valid, l2_lru_way, l2_victim_way;
   logic [7:0]  l1_way_sector;
   logic [1:0]  l1_lru_way, l1_victim_way;
   logic [15:0] l2_way_valid;
   logic [31:0] l2_way_sector;
   wire  [2:0]  sr_op1 = sr_key[13:11];
   wire  [3:0]  sr_crn = sr_key[10:7];
   wire  [3:0]  sr_crm = sr_key[6:3];
   wire  [2:0]  sr_op2 = sr_key[2:0];
   int          n_errors = 0;
   int          n_tests = 0;
   logic [13:0] keys [6] = '{SCC_KEY_CTRL, SCC_KEY_ALLOC, SCC_KEY_SET0, SCC_KEY_SET1,
                             SCC_KEY_L1CAP, SCC_KEY_WIN};
   logic [63:0] masks [6] = '{64'hc000000000000000, SCC_ALLOC_MASK, SCC_L2CAP_MASK,
                              SCC_L2CAP_MASK, SCC_L1CAP_MASK, SCC_L2CAP_MASK};
   scc_core_model core (.*);
   scc_sector_ctrl uut (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic wrap_up();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic sr(input logic w, input logic [1:0] el, input logic sec,
                     input logic [13:0] k, input logic [63:0] d, input logic [63:0] rd,
                     input logic t, input logic [1:0] tel, input logic u);
      logic ok;
      core.access(w, el, sec, k, d, ok);
      chk(ok, 1'b1);
      chk({sr_trap, sr_trap ? sr_trap_el : 2'h0, sr_trap_class, sr_undef},
          {t, t ? tel : 2'h0, t ? SCC_TRAP_CLASS : 6'h0, u});
      if (!w) chk(sr_rdata, rd);
   endtask
   // tag field 01 in address bits 57:56 on every access
   task automatic tag(input logic [2:0] fct, input logic [5:0] exp);
      @(negedge clk);
      {acc_valid, acc_fetch, acc_cacheable, acc_tag_enable} = {1'b1, fct};
      acc_addr = 64'h0100000000000000;
      @(negedge clk);
      acc_valid = 1'b0;
      acc_addr = ~acc_addr;
      chk({l1_sector_valid, l1_sector_valid ? l1_sector : 2'h0,
           l2_sector_valid, l2_sector_valid ? l2_sector : 2'h0}, exp);
   endtask
   task automatic hit(input logic [1:0] ls, input logic [1:0] as, input logic [2:0] exp);
      @(negedge clk);
      {hit_valid, hit_line_sector, hit_acc_sector} = {1'b1, ls, as};
      @(negedge clk);
      hit_valid = 1'b0;
      chk({line_sector_wr, line_sector_wr ? line_sector_new : 2'h0}, exp);
   endtask
   // ways 1 and 2 hold sector 1, ways 0 and 3 sector 0
   task automatic fill1(input logic part_on, input logic [3:0] v, input logic [1:0] exp);
      @(negedge clk);
      {l1_partition_en, l1_fill_req, l1_fill_sector, l1_way_valid} = {part_on, 1'b1, 2'h2, v};
      {l1_way_sector, l1_lru_way} = {8'h14, 2'h3};
      @(negedge clk);
      l1_fill_req = 1'b0;
      chk({l1_victim_valid, l1_victim_way, l1_store_sector}, {1'b1, exp, 2'h2});
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      wrap_up();
   end
   initial begin
      {resetn, peer_set_wr, peer_set_sel, peer_set_data, acc_valid, acc_fetch, acc_cacheable,
       acc_tag_enable, acc_addr, hit_valid, hit_line_sector, hit_acc_sector, l1_partition_en,
       l1_fill_req, l1_fill_sector, l1_way_valid, l1_way_sector, l1_lru_way, l2_partition_en,
       l2_fill_req, l2_fill_sector, l2_way_valid, l2_way_sector, l2_lru_way} = '0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      for (int i = 0; i < 6; i++) sr(1'b0, 2'h1, 1'b1, keys[i], '0, '0, 0, 0, 0);
      for (int i = 0; i < 6; i++) begin
         sr(1'b1, 2'h2, 1'b0, keys[i], '1, '0, 0, 0, 0);
         if (i >= 2 && i != 4) chk({set_wr, set_wr_sel}, {1'b1, i != 2});
      end
      for (int i = 0; i < 6; i++) sr(1'b0, 2'h3, 1'b0, keys[i], '0, masks[i], 0, 0, 0);
      for (int p = 0; p < 2; p++) begin
         sr(1'b1, 2'h2, 1'b0, SCC_KEY_ALLOC, 64'(p) << 2, '0, 0, 0, 0);
         sr(1'b1, 2'h2, 1'b0, SCC_KEY_WIN, 64'h0a05 >> p, '0, 0, 0, 0);
         chk({set_wr, set_wr_sel}, {1'b1, p[0]});
         chk(set_wr_data, 64'h0a05 >> p);
         sr(1'b0, 2'h2, 1'b0, p ? SCC_KEY_SET1 : SCC_KEY_SET0, '0, 64'h0a05 >> p, 0, 0, 0);
      end
      @(negedge clk);
      {peer_set_wr, peer_set_sel, peer_set_data} = {1'b1, 1'b0, 64'hffff000000001234};
      @(negedge clk);
      peer_set_wr = 1'b0;
      sr(1'b0, 2'h2, 1'b0, SCC_KEY_SET0, '0, 64'h1214, 0, 0, 0);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_CTRL, '0, '0, 0, 0, 0);
      sr(1'b0, 2'h1, 1'b0, SCC_KEY_ALLOC, '0, '0, 1, 2'h2, 0);
      sr(1'b0, 2'h1, 1'b0, SCC_KEY_CTRL, '0, '0, 0, 0, 0);
      sr(1'b1, 2'h1, 1'b0, SCC_KEY_CTRL, '1, '0, 1, 2'h2, 0);
      sr(1'b0, 2'h2, 1'b0, SCC_KEY_CTRL, '0, '0, 0, 0, 0);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_CTRL, 64'h4000000000000000, '0, 0, 0, 0);
      sr(1'b0, 2'h0, 1'b0, SCC_KEY_WIN, '0, '0, 1, 2'h1, 0);
      sr(1'b1, 2'h1, 1'b1, SCC_KEY_CTRL, 64'h8000000000000000, '0, 0, 0, 0);
      sr(1'b0, 2'h1, 1'b0, SCC_KEY_ALLOC, '0, 64'h4, 0, 0, 0);
      sr(1'b0, 2'h0, 1'b0, SCC_KEY_L1CAP, '0, '0, 1, 2'h1, 0);
      sr(1'b1, 2'h1, 1'b0, SCC_KEY_CTRL, 64'h4000000000000000, '0, 0, 0, 0);
      sr(1'b0, 2'h1, 1'b0, SCC_KEY_CTRL, '0, 64'hc000000000000000, 0, 0, 0);
      sr(1'b0, 2'h0, 1'b0, SCC_KEY_WIN, '0, 64'h0502, 0, 0, 0);
      sr(1'b0, 2'h0, 1'b0, SCC_KEY_ALLOC, '0, '0, 0, 0, 1);
      sr(1'b0, 2'h2, 1'b0, 14'h0000, '0, '0, 0, 0, 1);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_ALLOC, 64'h6, '0, 0, 0, 0);
      tag(3'b010, 6'h36);
      tag(3'b011, 6'h2f);
      tag(3'b111, 6'h06);
      tag(3'b001, 6'h00);
      hit(2'h2, 2'h1, 3'h5);
      hit(2'h3, 2'h3, 3'h0);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_ALLOC, 64'he, '0, 0, 0, 0);
      hit(2'h2, 2'h1, 3'h0);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_L1CAP, 64'h7727, '0, 0, 0, 0);
      fill1(1'b1, 4'hf, 2'h1);
      fill1(1'b0, 4'hf, 2'h3);
      fill1(1'b1, 4'hb, 2'h2);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_L1CAP, 64'h7737, '0, 0, 0, 0);
      fill1(1'b1, 4'hf, 2'h3);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_SET0, 64'h1f1f, '0, 0, 0, 0);
      sr(1'b1, 2'h2, 1'b0, SCC_KEY_SET1, 64'h1f01, '0, 0, 0, 0);
      @(negedge clk);
      {l2_partition_en, l2_fill_req, l2_fill_sector, l2_way_valid} = {2'h3, 2'h3, 16'hffff};
      {l2_way_sector, l2_lru_way} = {32'h00000800, 4'hc};
      @(negedge clk);
      l2_fill_req = 1'b0;
      chk({l2_victim_valid, l2_victim_way, l2_store_sector}, {1'b1, 4'h5, 2'h3});
      wrap_up();
   end
endmodule
`default_nettype wire
